/* File: inc/scd_map.vh */
// constants of the satellite carrier deframer: positions, counts, codes
// ****************************************************************
// Overview of operation
// - sync search tests one bit position for 16 frames, then slips one bit
// - after sync is found, extraction starts at the next superframe start
// - lock indicator rises with the first extracted bit on the main stream
// - error-free input locks within 16 times frame length squared composite periods
// - non-overhead composite bits are written to the rate FIFO, overhead never
// - FIFO is read one bit per intermediate clock onto the main stream
// - voice, data and alarm clocks are divided down from the composite clock
// - service bits are buffered and leave on the next falling edge of their clock
// - frame, subframe and bit counters route bits to FIFO, buffers or discard
// - active-low core reset initialises all but FIFO storage; release seen by intermediate clock
// - rate select 00,01,10,11 picks 2.048/8.448/16.896/34.368; 16.896 uses 176
// - composite input is sampled on each composite clock rising edge
// - lock indicator is timed by intermediate clock, only after multiframe lock
// - main stream changes only on intermediate edges, payload without overhead
// - backward alarm clock is 1 kHz with 50 percent duty
// - alarm outputs carry A1..A4, update on alarm clock falling edge
// - service data clock 8 kHz, 50 percent; data output updates on falling edge
// - one 32 kHz voice clock serves P1 and P2 outputs, update on falling edge
// ****************************************************************
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// rate select codes
`define SCD_RATE_2M 2'b00
`define SCD_RATE_8M 2'b01
`define SCD_RATE_16M 2'b10
`define SCD_RATE_34M 2'b11

// data bits per subframe for each rate
`define SCD_DBITS_2M 11'd64
`define SCD_DBITS_8M 11'd128
`define SCD_DBITS_16M 11'd176
`define SCD_DBITS_34M 11'd352

// frame layout: subframe 0 opens with the overhead bits
`define SCD_LAST_SUB 2'd3
`define SCD_OH_BITS 11'd8
`define SCD_SYNC_POS 11'd0
`define SCD_ALARM_POS 11'd1
`define SCD_DATA_POS 11'd2
`define SCD_P1_POS 11'd3
`define SCD_P2_POS 11'd4

// multiframe sync search
`define SCD_SYNC_PATTERN 16'h1f35
`define SCD_SEARCH_LAST 4'hf
`define SCD_LAST_FRAME 4'hf

// rate fifo
`define SCD_FIFO_WIDTH 1
`define SCD_FIFO_DEPTH 8
`define SCD_FIFO_AW 3

// half periods of derived clocks, in composite periods (8.554 / 34.464 MHz)
`define SCD_VOICE_HALF_LO 16'd134
`define SCD_VOICE_HALF_HI 16'd539
`define SCD_DATA_HALF_LO 16'd535
`define SCD_DATA_HALF_HI 16'd2154
`define SCD_ALARM_HALF_LO 16'd4277
`define SCD_ALARM_HALF_HI 16'd17232

`endif

/* File: verilog/scd_fifo.v */
// small synchronous fifo with valid and ready on both sides
`include "scd_map.vh"
`default_nettype none

module scd_fifo #(
  parameter WIDTH = `SCD_FIFO_WIDTH,
  parameter DEPTH = `SCD_FIFO_DEPTH,
  parameter AW = `SCD_FIFO_AW
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire do_wr;
  wire do_rd;

  // full and empty straight from the occupancy count
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // storage has no reset; only pointers define contents
  always @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr_r] <= in_data;
  end

  // pointers and count; flush empties in one cycle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_wr && !do_rd)
        count_r <= count_r + 1'b1;
      else if (do_rd && !do_wr)
        count_r <= count_r - 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/scd_clkdiv.v */
// divider making a slow square clock from composite clock ticks
`default_nettype none

module scd_clkdiv (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // composite tick and half period in ticks
  input wire tick,
  input wire [15:0] half_cnt,
  // divided clock and its falling-edge pulse
  output reg clk_out,
  output reg fall
);

  reg [15:0] cnt_r;

  // toggle every half period; equal halves give 50 percent duty
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 16'h0000;
      clk_out <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      fall <= 1'b0;
      if (tick)
      begin
        if (cnt_r >= half_cnt - 16'h0001)
        begin
          cnt_r <= 16'h0000;
          clk_out <= ~clk_out;
          fall <= clk_out;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

/* File: verilog/scd_top.v */
// satellite carrier deframer: sync search, overhead strip, service channels
`include "scd_map.vh"
`default_nettype none

module scd_top #(
  parameter [15:0] VOICE_HALF_LO = `SCD_VOICE_HALF_LO,
  parameter [15:0] VOICE_HALF_HI = `SCD_VOICE_HALF_HI,
  parameter [15:0] DATA_HALF_LO = `SCD_DATA_HALF_LO,
  parameter [15:0] DATA_HALF_HI = `SCD_DATA_HALF_HI,
  parameter [15:0] ALARM_HALF_LO = `SCD_ALARM_HALF_LO,
  parameter [15:0] ALARM_HALF_HI = `SCD_ALARM_HALF_HI
) (
  // system
  input wire clk,
  input wire reset_n,
  // configuration
  input wire [1:0] rate_select,
  // composite side
  input wire composite_rate_clock,
  input wire composite_serial_in,
  // main stream side
  input wire intermediate_rate_clock,
  output reg lock_indicator,
  output reg main_stream_out,
  // backward alarms
  output wire backward_alarm_clock,
  output reg [3:0] backward_alarm_out,
  // service channels
  output wire service_data_clock,
  output reg service_data_out,
  output wire service_voice_clock,
  output reg service_voice_ch1_out,
  output reg service_voice_ch2_out
);

  localparam ST_SEARCH = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RUN = 2'd2;

  reg rst_meta_r;
  reg rst_sync_r;
  reg core_run_r;
  reg cr_d_r;
  reg ir_d_r;
  reg [1:0] state_r;
  reg [10:0] bit_r;
  reg [1:0] sub_r;
  reg [3:0] frame_r;
  reg [15:0] hunt_r;
  reg [3:0] hunt_cnt_r;
  reg slip_r;
  reg [3:0] alarm_buf_r;
  reg data_buf_r;
  reg p1_buf_r;
  reg p2_buf_r;
  reg [10:0] dbits;
  reg [3:0] rot_sel;
  reg rot_hit;
  integer i;
  wire cr_tick;
  wire ir_tick;
  wire [10:0] last_bit;
  wire frame_end;
  wire is_oh;
  wire [15:0] cand;
  wire [31:0] pat2;
  wire [15:0] rot_match;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [0:0] fifo_out_data;
  wire hi_rate;
  wire alarm_fall;
  wire data_fall;
  wire voice_fall;

  // ****************************************************************
  // reset release and clock edges
  // ****************************************************************

  // two-flop release of the asynchronous reset
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // edge detect of the incoming rate clocks; core waits for an ir edge
  always @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      cr_d_r <= 1'b0;
      ir_d_r <= 1'b0;
      core_run_r <= 1'b0;
    end
    else
    begin
      cr_d_r <= composite_rate_clock;
      ir_d_r <= intermediate_rate_clock;
      if (ir_tick)
        core_run_r <= 1'b1;
    end
  end

  assign cr_tick = composite_rate_clock & ~cr_d_r & core_run_r;
  assign ir_tick = intermediate_rate_clock & ~ir_d_r;

  // ****************************************************************
  // frame geometry
  // ****************************************************************

  // data bits per subframe from the rate select
  always @*
  begin
    case (rate_select)
      `SCD_RATE_2M: dbits = `SCD_DBITS_2M;
      `SCD_RATE_8M: dbits = `SCD_DBITS_8M;
      `SCD_RATE_16M: dbits = `SCD_DBITS_16M;
      `SCD_RATE_34M: dbits = `SCD_DBITS_34M;
      default: dbits = `SCD_DBITS_2M;
    endcase
  end

  // subframe 0 is longer by the overhead bits
  assign last_bit = (sub_r == 2'd0) ? (dbits + `SCD_OH_BITS - 11'd1) : (dbits - 11'd1);
  assign frame_end = (bit_r == last_bit) && (sub_r == `SCD_LAST_SUB);
  assign is_oh = (sub_r == 2'd0) && (bit_r < `SCD_OH_BITS);

  // ****************************************************************
  // multiframe sync hunt
  // ****************************************************************

  // any rotation counts, so 16 samples always suffice at a right position
  assign cand = {hunt_r[14:0], composite_serial_in};
  assign pat2 = {`SCD_SYNC_PATTERN, `SCD_SYNC_PATTERN};

  genvar k;
  generate
    for (k = 0; k < 16; k = k + 1)
    begin : g_rot
      assign rot_match[k] = (cand == pat2[31-k -: 16]);
    end
  endgenerate

  // lowest matching rotation gives the multiframe phase
  always @*
  begin
    rot_hit = 1'b0;
    rot_sel = 4'h0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (rot_match[i])
      begin
        rot_hit = 1'b1;
        rot_sel = i[3:0];
      end
    end
  end

  // counters and search state machine, one step per composite edge
  always @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      state_r <= ST_SEARCH;
      bit_r <= 11'h000;
      sub_r <= 2'd0;
      frame_r <= 4'h0;
      hunt_r <= 16'h0000;
      hunt_cnt_r <= 4'h0;
      slip_r <= 1'b0;
    end
    else if (cr_tick)
    begin
      // counter advance; a slip holds the count one bit
      if (slip_r)
        slip_r <= 1'b0;
      else if (bit_r == last_bit)
      begin
        bit_r <= 11'h000;
        sub_r <= (sub_r == `SCD_LAST_SUB) ? 2'd0 : sub_r + 2'd1;
        if (frame_end)
          frame_r <= frame_r + 4'h1;
      end
      else
        bit_r <= bit_r + 11'h001;
      case (state_r)
        ST_SEARCH:
        begin
          if (!slip_r && is_oh && bit_r == `SCD_SYNC_POS)
          begin
            hunt_r <= cand;
            if (rot_hit && hunt_cnt_r == `SCD_SEARCH_LAST)
            begin
              state_r <= ST_WAIT;
              frame_r <= rot_sel - 4'h1;
              hunt_cnt_r <= 4'h0;
            end
            else if (hunt_cnt_r == `SCD_SEARCH_LAST)
            begin
              slip_r <= 1'b1;
              hunt_cnt_r <= 4'h0;
            end
            else
              hunt_cnt_r <= hunt_cnt_r + 4'h1;
          end
        end
        ST_WAIT:
        begin
          if (frame_end && frame_r == `SCD_LAST_FRAME)
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          // overflow means lost alignment; search again
          if (fifo_in_valid && !fifo_in_ready)
          begin
            state_r <= ST_SEARCH;
            hunt_r <= 16'h0000;
          end
        end
        default:
          state_r <= ST_SEARCH;
      endcase
    end
  end

  // ****************************************************************
  // main stream path
  // ****************************************************************

  assign fifo_in_valid = cr_tick && (state_r == ST_RUN) && !is_oh;
  assign fifo_out_ready = ir_tick && (state_r == ST_RUN);

  scd_fifo #(
    .WIDTH(`SCD_FIFO_WIDTH),
    .DEPTH(`SCD_FIFO_DEPTH),
    .AW(`SCD_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_r),
    .flush(state_r != ST_RUN),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(composite_serial_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // output bit and lock set together on an intermediate edge; lock clears as soon as the run state is left
  always @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      main_stream_out <= 1'b0;
      lock_indicator <= 1'b0;
    end
    else if (state_r != ST_RUN)
      lock_indicator <= 1'b0;
    else if (fifo_out_valid && fifo_out_ready)
    begin
      main_stream_out <= fifo_out_data[0];
      lock_indicator <= 1'b1;
    end
  end

  // ****************************************************************
  // service channels
  // ****************************************************************

  // overhead bits land in holding buffers, one bit each but four for the alarms
  always @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      alarm_buf_r <= 4'h0;
      data_buf_r <= 1'b0;
      p1_buf_r <= 1'b0;
      p2_buf_r <= 1'b0;
    end
    else if (cr_tick && state_r == ST_RUN && is_oh)
    begin
      if (bit_r == `SCD_ALARM_POS)
        alarm_buf_r[frame_r[1:0]] <= composite_serial_in;
      if (bit_r == `SCD_DATA_POS)
        data_buf_r <= composite_serial_in;
      if (bit_r == `SCD_P1_POS)
        p1_buf_r <= composite_serial_in;
      if (bit_r == `SCD_P2_POS)
        p2_buf_r <= composite_serial_in;
    end
  end

  assign hi_rate = (rate_select == `SCD_RATE_34M);

  scd_clkdiv u_alarm_div (
    .clk(clk),
    .rst_n(rst_sync_r),
    .tick(cr_tick),
    .half_cnt(hi_rate ? ALARM_HALF_HI : ALARM_HALF_LO),
    .clk_out(backward_alarm_clock),
    .fall(alarm_fall)
  );

  scd_clkdiv u_data_div (
    .clk(clk),
    .rst_n(rst_sync_r),
    .tick(cr_tick),
    .half_cnt(hi_rate ? DATA_HALF_HI : DATA_HALF_LO),
    .clk_out(service_data_clock),
    .fall(data_fall)
  );

  scd_clkdiv u_voice_div (
    .clk(clk),
    .rst_n(rst_sync_r),
    .tick(cr_tick),
    .half_cnt(hi_rate ? VOICE_HALF_HI : VOICE_HALF_LO),
    .clk_out(service_voice_clock),
    .fall(voice_fall)
  );

  // outputs change at falling edges, so they are steady at rising edges
  always @(posedge clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      backward_alarm_out <= 4'h0;
      service_data_out <= 1'b0;
      service_voice_ch1_out <= 1'b0;
      service_voice_ch2_out <= 1'b0;
    end
    else
    begin
      if (alarm_fall)
        backward_alarm_out <= alarm_buf_r;
      if (data_fall)
        service_data_out <= data_buf_r;
      if (voice_fall)
      begin
        service_voice_ch1_out <= p1_buf_r;
        service_voice_ch2_out <= p2_buf_r;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/scd_chk.sv */
// assertion checker on the deframer top ports
`default_nettype none

module scd_chk #(
  parameter logic [15:0] VOICE_HALF_LO = 16'h0086,
  parameter logic [15:0] DATA_HALF_LO = 16'h0217,
  parameter logic [15:0] ALARM_HALF_LO = 16'h10b5
) (
  // system
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] rate_select,
  // composite and main stream
  input wire logic composite_rate_clock,
  input wire logic composite_serial_in,
  input wire logic intermediate_rate_clock,
  input wire logic lock_indicator,
  input wire logic main_stream_out,
  // service outputs
  input wire logic backward_alarm_clock,
  input wire logic [3:0] backward_alarm_out,
  input wire logic service_data_clock,
  input wire logic service_data_out,
  input wire logic service_voice_clock,
  input wire logic service_voice_ch1_out,
  input wire logic service_voice_ch2_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // helper counters
  // ****************************************
  logic cr_q;
  logic [2:0] ck_q;
  logic [2:0] seen;
  logic [15:0] cnt [3];
  wire logic [2:0] ck = {backward_alarm_clock, service_data_clock, service_voice_clock};
  wire logic [2:0] tog = ck ^ ck_q;
  wire logic rise = composite_rate_clock & ~cr_q;

  // composite edges since each derived clock last toggled; first window skipped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cr_q <= 1'b0;
      ck_q <= 3'h0;
      seen <= 3'h0;
      cnt <= '{default: 16'h0000};
    end
    else
    begin
      cr_q <= composite_rate_clock;
      ck_q <= ck;
      seen <= seen | tog;
      for (int i = 0; i < 3; i++)
        cnt[i] <= tog[i] ? 16'h0000 : cnt[i] + {15'h0000, rise};
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_stream_edge;
    $changed(main_stream_out) |-> $past(intermediate_rate_clock)
      || $past(intermediate_rate_clock, 2);
  endproperty
  a_stream_edge: assert property (p_stream_edge)
    else $error("main stream moved without a read edge");

  property p_lock_edge;
    $rose(lock_indicator) |-> $past(intermediate_rate_clock) || $past(intermediate_rate_clock, 2);
  endproperty
  a_lock_edge: assert property (p_lock_edge)
    else $error("lock rose away from a read edge");

  property p_lock_release;
    $rose(reset_n) |-> !lock_indicator [*3];
  endproperty
  a_lock_release: assert property (p_lock_release)
    else $error("lock high straight after reset");

  property p_alarm_upd;
    $changed(backward_alarm_out) |-> !$past(backward_alarm_clock) && $past(backward_alarm_clock, 2);
  endproperty
  a_alarm_upd: assert property (p_alarm_upd)
    else $error("alarm outputs moved off the clock fall");

  property p_data_upd;
    $changed(service_data_out) |-> !service_data_clock
      && ($past(service_data_clock) || $past(service_data_clock, 2));
  endproperty
  a_data_upd: assert property (p_data_upd)
    else $error("service data moved off the clock fall");

  property p_voice_upd;
    $changed({service_voice_ch1_out, service_voice_ch2_out}) |-> $fell(service_voice_clock)
      || $past(service_voice_clock, 2) && !$past(service_voice_clock);
  endproperty
  a_voice_upd: assert property (p_voice_upd)
    else $error("voice outputs moved off the clock fall");

  property p_voice_half;
    tog[0] && seen[0] && rate_select == 2'h0 |-> cnt[0] + {15'h0000, rise} == VOICE_HALF_LO;
  endproperty
  a_voice_half: assert property (p_voice_half)
    else $error("voice clock half period wrong");

  property p_data_half;
    tog[1] && seen[1] && rate_select == 2'h0 |-> cnt[1] + {15'h0000, rise} == DATA_HALF_LO;
  endproperty
  a_data_half: assert property (p_data_half)
    else $error("data clock half period wrong");

  property p_alarm_half;
    tog[2] && seen[2] && rate_select == 2'h0 |-> cnt[2] + {15'h0000, rise} == ALARM_HALF_LO;
  endproperty
  a_alarm_half: assert property (p_alarm_half)
    else $error("alarm clock half period wrong");
endmodule

bind scd_top scd_chk #(.VOICE_HALF_LO(VOICE_HALF_LO), .DATA_HALF_LO(DATA_HALF_LO),
  .ALARM_HALF_LO(ALARM_HALF_LO)) i_scd_chk (.clk(clk), .reset_n(reset_n),
  .rate_select(rate_select), .composite_rate_clock(composite_rate_clock),
  .composite_serial_in(composite_serial_in), .intermediate_rate_clock(intermediate_rate_clock),
  .lock_indicator(lock_indicator), .main_stream_out(main_stream_out),
  .backward_alarm_clock(backward_alarm_clock), .backward_alarm_out(backward_alarm_out),
  .service_data_clock(service_data_clock), .service_data_out(service_data_out),
  .service_voice_clock(service_voice_clock), .service_voice_ch1_out(service_voice_ch1_out),
  .service_voice_ch2_out(service_voice_ch2_out));
`default_nettype wire

/* File: bench/scd_src.sv */
// composite source and intermediate clock model for the deframer bench
`default_nettype none

module scd_src (
  // clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic ir_en,
  // composite side
  output logic cr,
  output logic din,
  // main stream side
  output logic ir,
  // position of the bit on the line
  output int frm,
  output int pos
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NB = 264; // eight overhead bits plus four subframes of 64
  int cyc = 0;
  int k;

  // line bit at frame f, position b; payload end bit kept low so a
  // misaligned search sees no pattern
  function automatic logic bitv(input int f, input int b);
    logic [15:0] sp;
    logic [3:0] al;
    sp = 16'h1f35;
    al = 4'h6;
    case (b)
      0: return sp[15 - f % 16];
      1: return al[f % 4];
      2, 4: return 1'b1;
      3, 5, 6, 7, NB - 1: return 1'b0;
      default: return (f * 5 + b) % 7 < 3;
    endcase
  endfunction

  // one leading read edge, then one dummy bit so the search must slip once
  always @(negedge clk)
  begin
    if (!go)
    begin
      cyc <= 0;
      cr <= 1'b0;
      ir <= 1'b0;
      din <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      k = cyc / 4 - 1;
      cr <= cyc >= 4 && cyc % 4 == 0;
      ir <= cyc == 1 || (ir_en && cyc % 4 == 2 && k >= 1 && (k - 1) % NB >= 8);
      if (cyc >= 4 && cyc % 4 == 0)
      begin
        frm <= (k - 1) / NB;
        pos <= (k - 1) % NB;
        din <= k == 0 ? 1'b0 : bitv((k - 1) / NB, (k - 1) % NB);
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/test_satellite_carrier_deframer.sv */
// self-checking bench of the deframer at rate 2.048, voice divider also at rate 11
`default_nettype none

module test_satellite_carrier_deframer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic ir_en = 1'b1;
  logic [1:0] rsel = 2'h0;
  logic cr, din, ir, lock, ms, alck, sdck, svck, sd, v1, v2, e_bit;
  logic [3:0] alm;
  int frm, pos, e_frm, e_pos;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  scd_top #(.VOICE_HALF_LO(16'h0002), .DATA_HALF_LO(16'h0003), .ALARM_HALF_LO(16'h0004),
    .VOICE_HALF_HI(16'h0005))
    i_scd_top (.clk(clk), .reset_n(reset_n), .rate_select(rsel), .composite_rate_clock(cr),
    .composite_serial_in(din), .intermediate_rate_clock(ir), .lock_indicator(lock),
    .main_stream_out(ms), .backward_alarm_clock(alck), .backward_alarm_out(alm),
    .service_data_clock(sdck), .service_data_out(sd), .service_voice_clock(svck),
    .service_voice_ch1_out(v1), .service_voice_ch2_out(v2));
  scd_src i_scd_src (.clk(clk), .go(go), .ir_en(ir_en), .cr(cr), .din(din), .ir(ir),
    .frm(frm), .pos(pos));

  // ****************************************
  // shared tasks
  // ****************************************
  // the bit on the line when a read edge is seen
  always @(posedge clk)
  begin
    if (ir)
    begin
      e_bit <= din;
      e_frm <= frm;
      e_pos <= pos;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // next read edge, then wait until its answer has landed
  task automatic wait_read();
    int n;
    n = 0;
    do @(posedge clk); while (ir !== 1'b1 && ++n < 100);
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic end_sim();
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lock();
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 9000)
    begin
      wait_read();
      n++;
    end
    check("lock_indicator", lock, 1'b1);
    check("first bit", ms, e_bit);
    check("first frame", e_frm, 32);
    check("first position", e_pos, 8);
  endtask

  task automatic t_stream();
    repeat (1100)
    begin
      wait_read();
      check("main_stream_out", ms, e_bit);
    end
    check("lock held", lock, 1'b1);
  endtask

  task automatic t_service();
    check("alarm out", alm, 4'h6);
    check("data out", sd, 1'b1);
    check("voice out", {v1, v2}, 2'b01);
  endtask

  // reads stall so the fifo fills until it refuses and search restarts
  task automatic t_overflow();
    ir_en <= 1'b0;
    repeat (100) @(negedge clk);
    check("lock after overflow", lock, 1'b0);
    ir_en <= 1'b1;
  endtask

  task automatic t_reset();
    reset_n = 1'b0;
    @(negedge clk);
    check("outputs in reset", {lock, ms, alm, sd, v1, v2, alck, sdck, svck}, 12'h000);
    go <= 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check("lock after reset", lock, 1'b0);
  endtask

  // rate 11 must move the voice divider onto its high half period
  task automatic t_rate();
    int n;
    logic v0;
    reset_n = 1'b0;
    rsel = 2'h3;
    go <= 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    go <= 1'b1;
    // skip to one toggle, then count cycles to the next; four per composite edge
    n = 0;
    v0 = svck;
    do @(negedge clk); while (svck === v0 && ++n < 500);
    n = 0;
    v0 = svck;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (svck === v0 && n < 500);
    check("voice half period at rate 11", n, 20);
  endtask

  // ceiling well above the roughly 40000 cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      end_sim();
    end
  end

  initial
  begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    go <= 1'b1;
    t_lock();
    t_stream();
    t_service();
    t_overflow();
    t_reset();
    t_rate();
    end_sim();
  end
endmodule
`default_nettype wire
